// [rtl/tic_pkg.sv]
/*
 * tic_pkg: constants and carrier types for the timer interrupt flag
 * and fast clock control block.
 * assumes: one 125 MHz clock; register bus is axi4-lite, 32-bit data.
 */
// Notes on behaviour
// - mask/flag bits 7 and 0 read zero
// - compare-a request at vector 3 when enabled
// - compare-b request at vector 9 when enabled
// - overflow request at vector 4 when enabled
// - compare-a match sets compare-a flag
// - taking a vector clears its flag
// - write one clears flag one cycle later
// - compare-b match sets compare-b flag
// - no pwm: counter overflow sets overflow flag
// - pwm: top compare match sets overflow flag
// - fast clock 64 MHz, low speed halves it
// - low speed refused while pll is system clock
// - fast clock enable selects asynchronous timer clocking outside compatibility mode
// - fast clock enable settable only with pll enabled
// - pll enable starts pll, reads one if sysclock
// - compatibility mode only for fuse code 0011
// - compatibility: 10-bit and 3-bit prescalers, synchronous
// - compatibility fast clock runs at 25.6 MHz
// - compatibility mux: sixteen clock choices including stop
package tic_pkg;

	localparam int          ADDR_W       = 8;
	localparam int          IDX_W        = 6;
	// register indices; byte address is four times the index
	localparam logic [5:0]  IDX_PLL      = 6'h27;
	localparam logic [5:0]  IDX_FLAGS    = 6'h38;
	localparam logic [5:0]  IDX_MASK     = 6'h39;
	localparam logic [5:0]  IDX_CLKSEL   = 6'h3C;
	// field positions
	localparam int          B_CMP_A      = 6;
	localparam int          B_CMP_B      = 5;
	localparam int          B_OVF        = 2;
	localparam int          B_LSM        = 7;
	localparam int          B_FAST_CLOCK_ENABLE       = 2;
	localparam int          B_PLL_ENABLE       = 1;
	localparam int          B_LOCK       = 0;
	localparam int          B_COMPAT     = 4;
	localparam logic [7:0]  FLAGS_RESET  = 8'h00;
	localparam logic [3:0]  SEL_RESET    = 4'h0;
	// interrupt vectors
	localparam logic [3:0]  VEC_CMP_A    = 4'h3;
	localparam logic [3:0]  VEC_OVF      = 4'h4;
	localparam logic [3:0]  VEC_CMP_B    = 4'h9;
	localparam logic [3:0]  FUSE_COMPAT  = 4'h3;
	// compatibility select codes: 0 stop, 1..4 fast/1..8, 5..15 sys/1..1024
	localparam logic [3:0]  SEL_STOP     = 4'h0;
	localparam logic [3:0]  SEL_PCK_BASE = 4'h1;
	localparam logic [3:0]  SEL_CK_BASE  = 4'h5;
	localparam int          CK_PRE_W     = 10;
	localparam int          PCK_PRE_W    = 3;
	// nominal fast clock rates in kHz, supplied by the pll
	localparam int          FAST_KHZ_HI  = 64000;
	localparam int          FAST_KHZ_LO  = 32000;
	localparam int          FAST_KHZ_CMP = 25600;
	localparam logic [1:0]  CAP_WAIT     = 2'h2;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef struct packed {
		logic cmp_a;
		logic cmp_b;
		logic cmp_top;
		logic ovf;
	} tic_evt_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] vector;
	} tic_irq_t;

endpackage : tic_pkg

// [rtl/tic_top.sv]
/*
 * tic_top: interrupt flags and masks of the 8-bit timer, fast clock
 * control and the compatibility prescaler, behind an axi4-lite slave.
 * assumes: counter events and acks come from logic on mclk_in; pll
 * status, pll-as-sysclock and fuse code come from outside and are
 * synchronised; fast_tick_in is a one-cycle enable at the pll rate.
 */
`timescale 1ns/10ps
module tic_top (
	input  wire logic                      mclk_in,
	input  wire logic                      reset_n_in,
	input  wire logic [tic_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic                      s_axi_awvalid_in,
	output logic                           s_axi_awready_out,
	input  wire logic [31:0]               s_axi_wdata_in,
	input  wire logic [3:0]                s_axi_wstrb_in,
	input  wire logic                      s_axi_wvalid_in,
	output logic                           s_axi_wready_out,
	output logic [1:0]                     s_axi_bresp_out,
	output logic                           s_axi_bvalid_out,
	input  wire logic                      s_axi_bready_in,
	input  wire logic [tic_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic                      s_axi_arvalid_in,
	output logic                           s_axi_arready_out,
	output logic [31:0]                    s_axi_rdata_out,
	output logic [1:0]                     s_axi_rresp_out,
	output logic                           s_axi_rvalid_out,
	input  wire logic                      s_axi_rready_in,
	input  wire tic_pkg::tic_evt_t         evt_in,
	input  wire logic                      pwm_a_enable_in,
	input  wire logic                      pwm_b_enable_in,
	input  wire logic                      global_irq_enable_in,
	input  wire logic                      irq_ack_in,
	input  wire logic [3:0]                irq_ack_vector_in,
	input  wire logic                      pll_lock_status_in,
	input  wire logic                      pll_is_sysclk_in,
	input  wire logic [3:0]                clock_select_fuses_in,
	input  wire logic                      fast_tick_in,
	output tic_pkg::tic_irq_t              irq_out,
	output logic                           pll_enable_out,
	output logic                           low_speed_select_out,
	output logic                           timer_async_out,
	output logic                           timer_tick_out
);
	import tic_pkg::*;

	////////////////////////////////////////////////////////////////////
	// synchronisers for pins

	logic [5:0] pin_s1_reg;
	logic [5:0] pin_s2_reg;
	logic       lock_s;
	logic       sysclk_s;
	logic [3:0] fuse_s;

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_s1_reg <= 6'h00;
			pin_s2_reg <= 6'h00;
		end else begin
			pin_s1_reg <= {pll_lock_status_in, pll_is_sysclk_in,
			               clock_select_fuses_in};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign lock_s   = pin_s2_reg[5];
	assign sysclk_s = pin_s2_reg[4];
	assign fuse_s   = pin_s2_reg[3:0];

	// fuse code is caught once after release, never under reset
	logic [1:0] cap_cnt_reg;
	logic       compat_reg;

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cap_cnt_reg <= 2'h0;
			compat_reg  <= 1'b0;
		end else if (cap_cnt_reg < CAP_WAIT) begin
			cap_cnt_reg <= cap_cnt_reg + 2'h1;
		end else if (cap_cnt_reg == CAP_WAIT) begin
			cap_cnt_reg <= cap_cnt_reg + 2'h1;
			compat_reg  <= (fuse_s == FUSE_COMPAT);
		end
	end

	////////////////////////////////////////////////////////////////////
	// axi4-lite write channel

	logic                 awready_reg;
	logic                 wready_reg;
	logic                 aw_full_reg;
	logic                 w_full_reg;
	logic [IDX_W-1:0]     aw_idx_reg;
	logic [7:0]           wdata_reg;
	logic                 wstrb0_reg;
	logic                 bvalid_reg;
	logic [1:0]           bresp_reg;
	logic                 wr_fire;
	logic                 wr_hit;

	assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
	assign wr_hit  = (aw_idx_reg == IDX_PLL) || (aw_idx_reg == IDX_FLAGS)
	              || (aw_idx_reg == IDX_MASK) || (aw_idx_reg == IDX_CLKSEL);

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_idx_reg  <= '0;
			wdata_reg   <= 8'h00;
			wstrb0_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_in && awready_reg) begin
				aw_full_reg <= 1'b1;
				awready_reg <= 1'b0;
				aw_idx_reg  <= s_axi_awaddr_in[ADDR_W-1:2];
			end
			if (s_axi_wvalid_in && wready_reg) begin
				w_full_reg <= 1'b1;
				wready_reg <= 1'b0;
				wdata_reg  <= s_axi_wdata_in[7:0];
				wstrb0_reg <= s_axi_wstrb_in[0];
			end
			if (wr_fire) begin
				aw_full_reg <= 1'b0;
				w_full_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_reg && s_axi_bready_in) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	logic wr_pll;
	logic wr_flags;
	logic wr_mask;
	logic wr_sel;

	assign wr_pll   = wr_fire & wstrb0_reg & (aw_idx_reg == IDX_PLL);
	assign wr_flags = wr_fire & wstrb0_reg & (aw_idx_reg == IDX_FLAGS);
	assign wr_mask  = wr_fire & wstrb0_reg & (aw_idx_reg == IDX_MASK);
	assign wr_sel   = wr_fire & wstrb0_reg & (aw_idx_reg == IDX_CLKSEL);

	////////////////////////////////////////////////////////////////////
	// pll control and status

	logic lsm_reg;
	logic fast_clock_enable_reg;
	logic pll_enable_reg;
	logic pll_enable_eff;

	assign pll_enable_eff = pll_enable_reg | sysclk_s;

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lsm_reg  <= 1'b0;
			fast_clock_enable_reg <= 1'b0;
			pll_enable_reg <= 1'b0;
		end else if (wr_pll) begin
			lsm_reg  <= wdata_reg[B_LSM] & ~sysclk_s;
			fast_clock_enable_reg <= wdata_reg[B_FAST_CLOCK_ENABLE] & pll_enable_eff;
			pll_enable_reg <= wdata_reg[B_PLL_ENABLE];
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupt mask and flags

	logic       en_a_reg;
	logic       en_b_reg;
	logic       en_ov_reg;
	logic       fl_a_reg;
	logic       fl_b_reg;
	logic       fl_ov_reg;
	logic [2:0] clr_pend_reg;
	logic       pwm_mode;
	logic       ov_set;
	logic [2:0] ack_clr;

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			en_a_reg  <= FLAGS_RESET[B_CMP_A];
			en_b_reg  <= FLAGS_RESET[B_CMP_B];
			en_ov_reg <= FLAGS_RESET[B_OVF];
		end else if (wr_mask) begin
			en_a_reg  <= wdata_reg[B_CMP_A];
			en_b_reg  <= wdata_reg[B_CMP_B];
			en_ov_reg <= wdata_reg[B_OVF];
		end
	end

	// clears land one cycle after the write, as a synchronisation stage
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clr_pend_reg <= 3'h0;
		end else if (wr_flags) begin
			clr_pend_reg <= {wdata_reg[B_CMP_A], wdata_reg[B_CMP_B],
			                 wdata_reg[B_OVF]};
		end else begin
			clr_pend_reg <= 3'h0;
		end
	end

	assign pwm_mode = pwm_a_enable_in | pwm_b_enable_in;
	assign ov_set   = pwm_mode ? evt_in.cmp_top : evt_in.ovf;
	assign ack_clr  = {irq_ack_in && (irq_ack_vector_in == VEC_CMP_A),
	                   irq_ack_in && (irq_ack_vector_in == VEC_CMP_B),
	                   irq_ack_in && (irq_ack_vector_in == VEC_OVF)};

	// a set arriving with a clear wins, so no event is lost
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fl_a_reg  <= 1'b0;
			fl_b_reg  <= 1'b0;
			fl_ov_reg <= 1'b0;
		end else begin
			fl_a_reg  <= evt_in.cmp_a
			          | (fl_a_reg & ~clr_pend_reg[2] & ~ack_clr[2]);
			fl_b_reg  <= evt_in.cmp_b
			          | (fl_b_reg & ~clr_pend_reg[1] & ~ack_clr[1]);
			fl_ov_reg <= ov_set
			          | (fl_ov_reg & ~clr_pend_reg[0] & ~ack_clr[0]);
		end
	end

	// lowest vector has priority when several requests are pending
	logic req_a;
	logic req_b;
	logic req_ov;

	assign req_a  = fl_a_reg & en_a_reg & global_irq_enable_in;
	assign req_b  = fl_b_reg & en_b_reg & global_irq_enable_in;
	assign req_ov = fl_ov_reg & en_ov_reg & global_irq_enable_in;

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_out <= '0;
		end else begin
			irq_out.valid <= req_a | req_b | req_ov;
			if (req_a) begin
				irq_out.vector <= VEC_CMP_A;
			end else if (req_ov) begin
				irq_out.vector <= VEC_OVF;
			end else if (req_b) begin
				irq_out.vector <= VEC_CMP_B;
			end else begin
				irq_out.vector <= 4'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// clock selection and compatibility prescaler

	logic [3:0]          sel_reg;
	logic [CK_PRE_W-1:0]  ck_cnt_reg;
	logic [PCK_PRE_W-1:0] pck_cnt_reg;
	logic                half_reg;
	logic [CK_PRE_W:0]    ck_tap;
	logic [PCK_PRE_W:0]   pck_tap;
	logic                fast_div;
	logic                tick_next;

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sel_reg <= SEL_RESET;
		end else if (wr_sel) begin
			sel_reg <= wdata_reg[3:0];
		end
	end

	// prescalers run only in compatibility mode to save toggling
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ck_cnt_reg  <= '0;
			pck_cnt_reg <= '0;
		end else if (compat_reg) begin
			ck_cnt_reg <= ck_cnt_reg + 1'b1;
			if (fast_tick_in) begin
				pck_cnt_reg <= pck_cnt_reg + 1'b1;
			end
		end
	end

	// low speed keeps every second fast tick
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			half_reg <= 1'b0;
		end else if (fast_tick_in) begin
			half_reg <= ~half_reg;
		end
	end

	assign ck_tap[0]  = 1'b1;
	assign pck_tap[0] = fast_tick_in;

	generate
		for (genvar k = 1; k <= CK_PRE_W; k++) begin : g_ck
			assign ck_tap[k] = &ck_cnt_reg[k-1:0];
		end
		for (genvar k = 1; k <= PCK_PRE_W; k++) begin : g_pck
			assign pck_tap[k] = fast_tick_in & (&pck_cnt_reg[k-1:0]);
		end
	endgenerate

	assign fast_div = fast_tick_in & (~lsm_reg | half_reg);

	always_comb begin
		tick_next = 1'b0;
		if (!compat_reg) begin
			tick_next = fast_clock_enable_reg ? fast_div : 1'b1;
		end else if (sel_reg == SEL_STOP) begin
			tick_next = 1'b0;
		end else if (sel_reg < SEL_CK_BASE) begin
			tick_next = pck_tap[2'(sel_reg - SEL_PCK_BASE)];
		end else begin
			tick_next = ck_tap[4'(sel_reg - SEL_CK_BASE)];
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			timer_tick_out       <= 1'b0;
			timer_async_out      <= 1'b0;
			pll_enable_out       <= 1'b0;
			low_speed_select_out <= 1'b0;
		end else begin
			timer_tick_out       <= tick_next;
			timer_async_out      <= fast_clock_enable_reg & ~compat_reg;
			pll_enable_out       <= pll_enable_eff;
			low_speed_select_out <= lsm_reg;
		end
	end

	////////////////////////////////////////////////////////////////////
	// axi4-lite read channel

	logic             arready_reg;
	logic             rvalid_reg;
	logic [7:0]       rdata_reg;
	logic [1:0]       rresp_reg;
	logic [IDX_W-1:0] ar_idx;
	logic [7:0]       rd_val;
	logic             rd_hit;

	assign ar_idx = s_axi_araddr_in[ADDR_W-1:2];

	always_comb begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		case (ar_idx)
			IDX_PLL: begin
				rd_val[B_LSM]  = lsm_reg;
				rd_val[B_FAST_CLOCK_ENABLE] = fast_clock_enable_reg;
				rd_val[B_PLL_ENABLE] = pll_enable_eff;
				rd_val[B_LOCK] = lock_s;
			end
			IDX_FLAGS: begin
				rd_val[B_CMP_A] = fl_a_reg;
				rd_val[B_CMP_B] = fl_b_reg;
				rd_val[B_OVF]   = fl_ov_reg;
			end
			IDX_MASK: begin
				rd_val[B_CMP_A] = en_a_reg;
				rd_val[B_CMP_B] = en_b_reg;
				rd_val[B_OVF]   = en_ov_reg;
			end
			IDX_CLKSEL: begin
				rd_val[3:0]      = sel_reg;
				rd_val[B_COMPAT] = compat_reg;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 8'h00;
			rresp_reg   <= RESP_OKAY;
		end else if (s_axi_arvalid_in && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_val;
			rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready_in) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end
	end

	assign s_axi_awready_out = awready_reg;
	assign s_axi_wready_out  = wready_reg;
	assign s_axi_bvalid_out  = bvalid_reg;
	assign s_axi_bresp_out   = bresp_reg;
	assign s_axi_arready_out = arready_reg;
	assign s_axi_rvalid_out  = rvalid_reg;
	assign s_axi_rresp_out   = rresp_reg;
	assign s_axi_rdata_out   = {24'h000000, rdata_reg};

	////////////////////////////////////////////////////////////////////
	// assertions

	logic rd_flag_reg;

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_flag_reg <= 1'b0;
		end else if (s_axi_arvalid_in && arready_reg) begin
			rd_flag_reg <= (ar_idx == IDX_FLAGS) || (ar_idx == IDX_MASK);
		end
	end

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!reset_n_in);

	rsv_read_a: assert property (
		s_axi_rvalid_out && rd_flag_reg
		|-> !s_axi_rdata_out[7] && !s_axi_rdata_out[0])
		else $error("reserved bit read as one");

	req_cmp_a_a: assert property (
		req_a |=> irq_out.valid && irq_out.vector == VEC_CMP_A)
		else $error("compare a request missing");

	req_cmp_b_a: assert property (
		req_b && !req_a && !req_ov
		|=> irq_out.valid && irq_out.vector == VEC_CMP_B)
		else $error("compare b request missing");

	req_ovf_a: assert property (
		req_ov && !req_a |=> irq_out.valid && irq_out.vector == VEC_OVF)
		else $error("overflow request missing");

	set_cmp_a_a: assert property (
		evt_in.cmp_a |=> fl_a_reg)
		else $error("compare a flag not set");

	ack_clear_a: assert property (
		irq_ack_in && irq_ack_vector_in == VEC_CMP_A && !evt_in.cmp_a
		|=> !fl_a_reg)
		else $error("ack did not clear flag");

	w1c_delay_a: assert property (
		wr_flags && wdata_reg[B_OVF] && fl_ov_reg && !ov_set && !ack_clr[0]
		|=> fl_ov_reg ##1 (!fl_ov_reg || $past(ov_set)))
		else $error("write one clear timing wrong");

	set_cmp_b_a: assert property (
		evt_in.cmp_b |=> fl_b_reg)
		else $error("compare b flag not set");

	ovf_norm_a: assert property (
		!pwm_mode && evt_in.ovf |=> fl_ov_reg)
		else $error("overflow flag not set");

	ovf_pwm_a: assert property (
		pwm_mode && !evt_in.cmp_top && !fl_ov_reg |=> !fl_ov_reg)
		else $error("overflow flag set outside top match");

	lsm_refuse_a: assert property (
		sysclk_s && !lsm_reg |=> !lsm_reg ##1 !low_speed_select_out)
		else $error("low speed set with pll sysclock");

	fast_clock_enable_guard_a: assert property (
		!pll_enable_eff && !fast_clock_enable_reg |=> !fast_clock_enable_reg)
		else $error("fast clock enabled without pll");

	compat_sync_a: assert property (
		compat_reg |=> !timer_async_out)
		else $error("async clocking in compatibility mode");

	stop_sel_a: assert property (
		compat_reg && sel_reg == SEL_STOP |=> !timer_tick_out)
		else $error("tick while stopped");

	cv_irq_c: cover property (irq_out.valid ##1 irq_ack_in);
	cv_async_c: cover property (fast_clock_enable_reg && fast_tick_in);
	cv_compat_c: cover property (compat_reg && timer_tick_out);

endmodule : tic_top

// [verification/tic_top_tb.sv]
/*
 * tic_top_tb: directed self-checking bench for tic_top (flags, masks,
 * pll control, compatibility prescaler) over axi4-lite.
 * assumes: rtl/tic_pkg.sv and rtl/tic_top.sv are compiled before it.
 */
`timescale 1ns/10ps
module tic_top_tb;
	import tic_pkg::*;
	logic        mclk_in = 1'b0, reset_n_in, irq_ack_in, global_irq_enable_in;
	logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
	logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
	logic        s_axi_arvalid_in, s_axi_rready_in;
	logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic        s_axi_arready_out, s_axi_rvalid_out;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
	logic [3:0]  s_axi_wstrb_in, irq_ack_vector_in, clock_select_fuses_in;
	logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
	tic_evt_t    evt_in;
	tic_irq_t    irq_out;
	logic        pwm_a_enable_in, pwm_b_enable_in, fast_tick_in = 1'b0;
	logic        pll_lock_status_in, pll_is_sysclk_in;
	logic        pll_enable_out, low_speed_select_out, timer_async_out, timer_tick_out;
	int          n_errors = 0;
	int          checked  = 0;
	localparam logic [7:0] A_PLL = {IDX_PLL, 2'b00};
	localparam logic [7:0] A_FLG = {IDX_FLAGS, 2'b00};
	localparam logic [7:0] A_MSK = {IDX_MASK, 2'b00};
	localparam logic [7:0] A_SEL = {IDX_CLKSEL, 2'b00};

	tic_top dut (.*);

	always #4 mclk_in = ~mclk_in;
	// pll-rate enable every other cycle; window length is a multiple of each tick period
	always @(posedge mclk_in) fast_tick_in <= ~fast_tick_in;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	// values are judged at the falling edge: inputs only move at rising edges
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic ta, tw, a1, w1;
		@(posedge mclk_in);
		s_axi_awaddr_in  <= a;
		s_axi_wdata_in   <= {24'h0, d};
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in  <= 1'b1;
		s_axi_bready_in  <= 1'b1;
		ta = 1'b0;
		tw = 1'b0;
		while (!(ta && tw)) begin
			@(negedge mclk_in);
			a1 = s_axi_awvalid_in && s_axi_awready_out;
			w1 = s_axi_wvalid_in && s_axi_wready_out;
			@(posedge mclk_in);
			if (a1) s_axi_awvalid_in <= 1'b0;
			if (w1) s_axi_wvalid_in <= 1'b0;
			ta = ta | a1;
			tw = tw | w1;
		end
		do @(negedge mclk_in); while (s_axi_bvalid_out !== 1'b1);
		chk({30'h0, s_axi_bresp_out}, {30'h0, er});
		@(posedge mclk_in);
		s_axi_bready_in <= 1'b0;
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		@(posedge mclk_in);
		s_axi_araddr_in  <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in  <= 1'b1;
		do @(negedge mclk_in); while (s_axi_arready_out !== 1'b1);
		@(posedge mclk_in);
		s_axi_arvalid_in <= 1'b0;
		do @(negedge mclk_in); while (s_axi_rvalid_out !== 1'b1);
		chk(s_axi_rdata_out, {24'h0, e});
		chk({30'h0, s_axi_rresp_out}, {30'h0, er});
		@(posedge mclk_in);
		s_axi_rready_in <= 1'b0;
	endtask : rchk

	task automatic pulse(input tic_evt_t e);
		@(posedge mclk_in);
		evt_in <= e;
		@(posedge mclk_in);
		evt_in <= '0;
		repeat (3) @(posedge mclk_in);
	endtask : pulse

	task automatic ack(input logic [3:0] v, input logic [3:0] nv, input logic nval);
		@(posedge mclk_in);
		irq_ack_in        <= 1'b1;
		irq_ack_vector_in <= v;
		@(posedge mclk_in);
		irq_ack_in <= 1'b0;
		repeat (4) @(negedge mclk_in);
		chk({27'h0, irq_out}, {27'h0, nval, nv});
	endtask : ack

	task automatic ticks(input int e, input int w);
		int n;
		n = 0;
		repeat (8) @(posedge mclk_in);
		repeat (w) begin
			@(negedge mclk_in);
			if (timer_tick_out === 1'b1) n++;
		end
		chk(n, e);
	endtask : ticks

	task automatic do_reset(input logic [3:0] f);
		@(posedge mclk_in);
		reset_n_in            <= 1'b0;
		clock_select_fuses_in <= f;
		repeat (3) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
	endtask : do_reset

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rchk(A_FLG, 8'h00, RESP_OKAY);
		rchk(A_MSK, 8'h00, RESP_OKAY);
		rchk(A_PLL, 8'h00, RESP_OKAY);
		rchk(A_SEL, 8'h00, RESP_OKAY);
		rchk(8'h00, 8'h00, RESP_SLVERR);
		wr(8'h00, 8'hFF, RESP_SLVERR);
		wr(A_MSK, 8'hFF, RESP_OKAY);
		rchk(A_MSK, 8'h64, RESP_OKAY);
		wr(A_FLG, 8'hFF, RESP_OKAY);
		rchk(A_FLG, 8'h00, RESP_OKAY);
		$display("test reset and reserved bits done");
	endtask : t_reset

	task automatic t_irq;
		global_irq_enable_in <= 1'b1;
		pulse(4'b1101);
		rchk(A_FLG, 8'h64, RESP_OKAY);
		chk({27'h0, irq_out}, {27'h0, 1'b1, VEC_CMP_A});
		ack(VEC_CMP_A, VEC_OVF, 1'b1);
		rchk(A_FLG, 8'h24, RESP_OKAY);
		ack(VEC_OVF, VEC_CMP_B, 1'b1);
		ack(VEC_CMP_B, 4'h0, 1'b0);
		rchk(A_FLG, 8'h00, RESP_OKAY);
		global_irq_enable_in <= 1'b0;
		pulse(4'b1101);
		chk({27'h0, irq_out}, 32'h0);
		wr(A_FLG, 8'h00, RESP_OKAY);
		rchk(A_FLG, 8'h64, RESP_OKAY);
		wr(A_FLG, 8'h40, RESP_OKAY);
		rchk(A_FLG, 8'h24, RESP_OKAY);
		wr(A_FLG, 8'h24, RESP_OKAY);
		rchk(A_FLG, 8'h00, RESP_OKAY);
		$display("test interrupts and flag clearing done");
	endtask : t_irq

	task automatic t_pwm;
		pwm_a_enable_in <= 1'b1;
		pulse(4'b0001);
		rchk(A_FLG, 8'h00, RESP_OKAY);
		pulse(4'b0010);
		rchk(A_FLG, 8'h04, RESP_OKAY);
		wr(A_FLG, 8'h04, RESP_OKAY);
		pwm_a_enable_in <= 1'b0;
		pwm_b_enable_in <= 1'b1;
		pulse(4'b0010);
		rchk(A_FLG, 8'h04, RESP_OKAY);
		wr(A_FLG, 8'h04, RESP_OKAY);
		pwm_b_enable_in <= 1'b0;
		pulse(4'b0010);
		rchk(A_FLG, 8'h00, RESP_OKAY);
		$display("test overflow source done");
	endtask : t_pwm

	task automatic t_pll;
		ticks(64, 64);
		@(posedge mclk_in);
		pll_lock_status_in <= 1'b1;
		wr(A_PLL, 8'h04, RESP_OKAY);
		rchk(A_PLL, 8'h01, RESP_OKAY);
		wr(A_PLL, 8'h02, RESP_OKAY);
		@(negedge mclk_in);
		chk({31'h0, pll_enable_out}, 32'h1);
		wr(A_PLL, 8'h06, RESP_OKAY);
		rchk(A_PLL, 8'h07, RESP_OKAY);
		chk({31'h0, timer_async_out}, 32'h1);
		ticks(32, 64);
		wr(A_PLL, 8'h86, RESP_OKAY);
		@(negedge mclk_in);
		chk({31'h0, low_speed_select_out}, 32'h1);
		ticks(16, 64);
		wr(A_PLL, 8'h04, RESP_OKAY);
		pll_is_sysclk_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
		wr(A_PLL, 8'h84, RESP_OKAY);
		rchk(A_PLL, 8'h07, RESP_OKAY);
		chk({31'h0, low_speed_select_out}, 32'h0);
		pll_is_sysclk_in <= 1'b0;
		wr(A_PLL, 8'h00, RESP_OKAY);
		$display("test pll control done");
	endtask : t_pll

	task automatic t_compat;
		int e;
		int w;
		do_reset(FUSE_COMPAT);
		rchk(A_SEL, 8'h10, RESP_OKAY);
		wr(A_PLL, 8'h02, RESP_OKAY);
		wr(A_PLL, 8'h06, RESP_OKAY);
		@(negedge mclk_in);
		chk({31'h0, timer_async_out}, 32'h0);
		ticks(0, 64);
		for (int s = 1; s < 16; s++) begin
			w = (s < 12) ? 64 : (1 << (s - 5));
			e = (s < 5) ? (32 >> (s - 1)) : (w >> (s - 5));
			wr(A_SEL, 8'(s), RESP_OKAY);
			ticks(e, w);
		end
		$display("test compatibility prescaler done");
	endtask : t_compat

	////////////////////////////////////////////////////////////////////////
	initial begin
		reset_n_in = 1'b0;
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
		{s_axi_arvalid_in, s_axi_rready_in, irq_ack_in, global_irq_enable_in} = '0;
		s_axi_wstrb_in = 4'hF;
		{irq_ack_vector_in, clock_select_fuses_in} = '0;
		evt_in = '0;
		{pwm_a_enable_in, pwm_b_enable_in} = '0;
		{pll_lock_status_in, pll_is_sysclk_in} = '0;
		repeat (3) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
		t_reset();
		t_irq();
		t_pwm();
		t_pll();
		t_compat();
		stop_test();
	end

	// whole run is near 30 us; this cuts a hang well after that
	initial begin
		#200000;
		n_errors++;
		$display("watchdog expired at %0t", $time);
		stop_test();
	end

endmodule : tic_top_tb
